// ---- rtl/dio_consts.vh ----
// offsets, field positions, reset values and timing counts of the dual port block
`ifndef DIO_CONSTS_VH
`define DIO_CONSTS_VH
`define DIO_REG_WORDS 128
`define DIO_WIN_SPAN 9'h100
`define DIO_OFF_P1_DIR 8'h50
`define DIO_OFF_P1_PIN 8'h52
`define DIO_OFF_P1_FSEL 8'h54
`define DIO_OFF_P1_LATCH 8'h56
`define DIO_OFF_P2_DIR 8'h58
`define DIO_OFF_P2_PIN 8'h5a
`define DIO_OFF_P2_FSEL 8'h5c
`define DIO_OFF_P2_LATCH 8'h5e
`define DIO_OFF_RELOC 8'hfe
`define DIO_RST_P1_DIR 8'h00
`define DIO_RST_P1_FSEL 8'h00
`define DIO_RST_P1_LATCH 8'hff
`define DIO_RST_P2_DIR 8'hff
`define DIO_RST_P2_FSEL 8'h00
`define DIO_RST_P2_LATCH 8'hff
`define DIO_RST_BASE 8'hff
`define DIO_RST_IOSPACE 1'b1
`define DIO_RELOC_IO_BIT 12
`define DIO_P2_IN_ONLY 8'h34
`define DIO_P2_OUT_ONLY 8'h0a
`define DIO_P2_OPEN_DRAIN 8'hc0
`define DIO_P2_BIDIR 8'h01
`define DIO_SYNC_STAGES 3
`endif

// ---- rtl/dio_pin_sync.v ----
// three-stage synchroniser for a group of pin inputs with agreement filter
`timescale 1ns/1ns
module dio_pin_sync #(
    parameter WIDTH = 8
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [WIDTH-1:0] pinRaw,
    output reg [WIDTH-1:0] pinClean
);
    reg [WIDTH-1:0] stageA;
    reg [WIDTH-1:0] stageB;
    reg [WIDTH-1:0] stageC;
    integer i;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stageA <= {WIDTH{1'b1}};
            stageB <= {WIDTH{1'b1}};
            stageC <= {WIDTH{1'b1}};
            pinClean <= {WIDTH{1'b1}};
        end else begin
            stageA <= pinRaw;
            stageB <= stageA;
            stageC <= stageB;
            // a bit changes only when second and third stage agree
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stageB[i] == stageC[i]) begin
                    pinClean[i] <= stageC[i];
                end
            end
        end
    end
endmodule // dio_pin_sync

// ---- rtl/dio_port_block.v ----
// two eight-bit general-purpose ports inside the relocatable peripheral register file
// What this block does
// - each first-port pin drives its output latch bit when set for port use.
// - second-port bit 0 works as input or output, chosen by direction.
// - second-port bits 1 and 3 are output-only, no input when port pins.
// - second-port bits 2, 4, 5 are input-only and readable by software.
// - second-port bits 6, 7 are open drain: pull low or release.
// - all peripheral registers share one file of 128 sixteen-bit words.
// - register file relocates to memory or I/O space on 256-byte boundaries.
`timescale 1ns/1ns
`include "dio_consts.vh"
module dio_port_block #(
    parameter ADDR_WIDTH = 20
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [ADDR_WIDTH-1:0] busAddr,
    input wire busIoSpace,
    input wire busWrite,
    input wire busRead,
    input wire [15:0] busWrData,
    output reg [15:0] busRdData,
    output reg busHit,
    output reg [6:0] regWordIndex,
    output reg regFileSelect,
    input wire [7:0] altFirstOut,
    input wire [7:0] altSecondOut,
    input wire [7:0] altSecondOe,
    output reg [7:0] altSecondIn,
    input wire [7:0] firstPortIn,
    output reg [7:0] firstPortOut,
    output reg [7:0] firstPortOe,
    input wire [7:0] secondPortIn,
    output reg [7:0] secondPortOut,
    output reg [7:0] secondPortOe
);
    reg [7:0] firstDir;
    reg [7:0] firstFsel;
    reg [7:0] firstLatch;
    reg [7:0] secondDir;
    reg [7:0] secondFsel;
    reg [7:0] secondLatch;
    reg [ADDR_WIDTH-9:0] relocBase;
    reg relocIoSpace;
    wire [7:0] firstPinSync;
    wire [7:0] secondPinSync;
    wire [7:0] offset;
    wire inWindow;
    reg [15:0] next_busRdData;
    reg next_hit;
    reg [7:0] next_firstOut;
    reg [7:0] next_firstOe;
    reg [7:0] next_secondOut;
    reg [7:0] next_secondOe;
    integer b;
    integer sb;
    integer rb;
    integer w;
    reg [7:0] secondReadable;
    // plain words of the peripheral register file
    reg [15:0] regFile [0:`DIO_REG_WORDS-1];

    // fixed classes of the second-port bits
    localparam ROLE_IN = 2'h0;
    localparam ROLE_OUT = 2'h1;
    localparam ROLE_BIDIR = 2'h2;
    localparam ROLE_OPEN_DRAIN = 2'h3;

    // word index of a byte offset inside the register file
    function [6:0] wordIndex;
        input [7:0] off;
        begin
            wordIndex = off[7:1];
        end
    endfunction

    // place an eight-bit field in the low byte of a bus word
    function [15:0] lowByte;
        input [7:0] v;
        begin
            lowByte = {8'h00, v};
        end
    endfunction

    // drive class of one second-port bit
    function [1:0] secondRole;
        input [2:0] idx;
        reg [7:0] sel;
        begin
            sel = 8'h01 << idx;
            if ((`DIO_P2_OPEN_DRAIN & sel) != 8'h00) begin
                secondRole = ROLE_OPEN_DRAIN;
            end else if ((`DIO_P2_OUT_ONLY & sel) != 8'h00) begin
                secondRole = ROLE_OUT;
            end else if ((`DIO_P2_BIDIR & sel) != 8'h00) begin
                secondRole = ROLE_BIDIR;
            end else begin
                secondRole = ROLE_IN;
            end
        end
    endfunction

    // words served by the port logic rather than the plain register file
    function portWord;
        input [7:0] off;
        begin
            portWord = ((off >= `DIO_OFF_P1_DIR) && (off <= `DIO_OFF_P2_LATCH + 8'h01))
                || (off == `DIO_OFF_RELOC);
        end
    endfunction

    dio_pin_sync #(.WIDTH(8)) firstSync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pinRaw(firstPortIn),
        .pinClean(firstPinSync)
    );

    dio_pin_sync #(.WIDTH(8)) secondSync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pinRaw(secondPortIn),
        .pinClean(secondPinSync)
    );

    // window decode: upper address bits match base, space matches selection
    assign offset = busAddr[7:0];
    assign inWindow = (busAddr[ADDR_WIDTH-1:8] == relocBase)
        && (busIoSpace == relocIoSpace);

    // register writes
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            firstDir <= `DIO_RST_P1_DIR;
            firstFsel <= `DIO_RST_P1_FSEL;
            firstLatch <= `DIO_RST_P1_LATCH;
            secondDir <= `DIO_RST_P2_DIR;
            secondFsel <= `DIO_RST_P2_FSEL;
            secondLatch <= `DIO_RST_P2_LATCH;
        end else if (busWrite && inWindow) begin
            if (offset == `DIO_OFF_P1_DIR) begin
                firstDir <= busWrData[7:0];
            end else if (offset == `DIO_OFF_P1_FSEL) begin
                firstFsel <= busWrData[7:0];
            end else if (offset == `DIO_OFF_P1_LATCH) begin
                firstLatch <= busWrData[7:0];
            end else if (offset == `DIO_OFF_P2_DIR) begin
                secondDir <= busWrData[7:0];
            end else if (offset == `DIO_OFF_P2_FSEL) begin
                secondFsel <= busWrData[7:0];
            end else if (offset == `DIO_OFF_P2_LATCH) begin
                secondLatch <= busWrData[7:0];
            end
        end
    end

    // window base and space; after reset the file sits in I/O page 0xff
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            relocBase <= {{(ADDR_WIDTH-16){1'b0}}, `DIO_RST_BASE};
            relocIoSpace <= `DIO_RST_IOSPACE;
        end else if (busWrite && inWindow && (offset == `DIO_OFF_RELOC)) begin
            // base counts 256-byte pages, so any aligned page can be chosen
            relocBase <= busWrData[ADDR_WIDTH-9:0];
            relocIoSpace <= busWrData[`DIO_RELOC_IO_BIT];
        end
    end

    // remaining words of the peripheral register file
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (w = 0; w < `DIO_REG_WORDS; w = w + 1) begin
                regFile[w] <= 16'h0000;
            end
        end else if (busWrite && inWindow && !portWord(offset)) begin
            regFile[wordIndex(offset)] <= busWrData;
        end
    end

    // read mux; words outside the port set come from the register file
    always @* begin
        next_busRdData = 16'h0000;
        next_hit = 1'b0;
        if (busRead && inWindow) begin
            next_hit = 1'b1;
            if (offset == `DIO_OFF_P1_DIR) begin
                next_busRdData = lowByte(firstDir);
            end else if (offset == `DIO_OFF_P1_PIN) begin
                next_busRdData = lowByte(firstPinSync);
            end else if (offset == `DIO_OFF_P1_FSEL) begin
                next_busRdData = lowByte(firstFsel);
            end else if (offset == `DIO_OFF_P1_LATCH) begin
                next_busRdData = lowByte(firstLatch);
            end else if (offset == `DIO_OFF_P2_DIR) begin
                next_busRdData = lowByte(secondDir);
            end else if (offset == `DIO_OFF_P2_PIN) begin
                // output-only bits have no input path and read zero
                next_busRdData = lowByte(secondPinSync & secondReadable);
            end else if (offset == `DIO_OFF_P2_FSEL) begin
                next_busRdData = lowByte(secondFsel);
            end else if (offset == `DIO_OFF_P2_LATCH) begin
                next_busRdData = lowByte(secondLatch);
            end else if (offset == `DIO_OFF_RELOC) begin
                next_busRdData = 16'h0000;
                next_busRdData[`DIO_RELOC_IO_BIT] = relocIoSpace;
                next_busRdData[ADDR_WIDTH-9:0] = relocBase;
            end else if (!portWord(offset)) begin
                next_busRdData = regFile[wordIndex(offset)];
            end
        end
    end

    // first port: always driven, latch or alternate function
    always @* begin
        next_firstOut = 8'h00;
        next_firstOe = 8'hff;
        for (b = 0; b < 8; b = b + 1) begin
            if (firstFsel[b]) begin
                next_firstOut[b] = altFirstOut[b];
            end else begin
                next_firstOut[b] = firstLatch[b];
            end
        end
    end

    // output-only bits have no input path and read zero
    always @* begin
        secondReadable = 8'h00;
        for (rb = 0; rb < 8; rb = rb + 1) begin
            secondReadable[rb] = (secondRole(rb[2:0]) != ROLE_OUT);
        end
    end

    // second port: fixed bit classes, alternate function where the pin has one
    always @* begin
        next_secondOut = 8'h00;
        next_secondOe = 8'h00;
        for (sb = 0; sb < 8; sb = sb + 1) begin
            case (secondRole(sb[2:0]))
                ROLE_IN: begin
                    // input-only bits stay released in every mode
                    next_secondOe[sb] = 1'b0;
                end
                ROLE_OPEN_DRAIN: begin
                    // pull low only, never drive high
                    next_secondOut[sb] = 1'b0;
                    next_secondOe[sb] = ~secondLatch[sb];
                end
                default: begin
                    if (secondFsel[sb]) begin
                        next_secondOut[sb] = altSecondOut[sb];
                        next_secondOe[sb] = altSecondOe[sb];
                    end else if (secondRole(sb[2:0]) == ROLE_OUT) begin
                        next_secondOut[sb] = secondLatch[sb];
                        next_secondOe[sb] = 1'b1;
                    end else begin
                        next_secondOut[sb] = secondLatch[sb];
                        next_secondOe[sb] = ~secondDir[sb];
                    end
                end
            endcase
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            busRdData <= 16'h0000;
            busHit <= 1'b0;
            regWordIndex <= 7'h00;
            regFileSelect <= 1'b0;
        end else begin
            busRdData <= next_busRdData;
            busHit <= next_hit;
            regWordIndex <= wordIndex(offset);
            regFileSelect <= inWindow & (busRead | busWrite);
        end
    end

    // pin drive and synchronised inputs for the alternate peripherals
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            altSecondIn <= 8'hff;
            firstPortOut <= 8'h00;
            firstPortOe <= 8'h00;
            secondPortOut <= 8'h00;
            secondPortOe <= 8'h00;
        end else begin
            altSecondIn <= secondPinSync;
            firstPortOut <= next_firstOut;
            firstPortOe <= next_firstOe;
            secondPortOut <= next_secondOut;
            secondPortOe <= next_secondOe;
        end
    end
endmodule // dio_port_block

// ---- verif/dio_board_model.sv ----
// board model: pull-ups on every port line and an external driver
`timescale 1ns/1ns
module dio_board_model (
    input wire [7:0] firstPortOut,
    input wire [7:0] firstPortOe,
    input wire [7:0] secondPortOut,
    input wire [7:0] secondPortOe,
    input wire [7:0] extVal,
    input wire [7:0] extOe,
    output wire [7:0] firstPortIn,
    output wire [7:0] secondPortIn
);
    // an undriven line floats high through its pull-up
    assign firstPortIn = ~(firstPortOe & ~firstPortOut);
    // wired-and of both parties, so released open-drain lines read high
    assign secondPortIn = ~((secondPortOe & ~secondPortOut) | (extOe & ~extVal));
endmodule // dio_board_model

// ---- verif/dio_port_block_properties.sv ----
// port-level assertions for the dual port block
`timescale 1ns/1ns
module dio_port_block_properties #(parameter ADDR_WIDTH = 20) (
    input wire sys_clk,
    input wire rst_b,
    input wire [ADDR_WIDTH-1:0] busAddr,
    input wire busWrite,
    input wire busRead,
    input wire [15:0] busRdData,
    input wire busHit,
    input wire [6:0] regWordIndex,
    input wire regFileSelect,
    input wire [7:0] firstPortOe,
    input wire [7:0] secondPortOut,
    input wire [7:0] secondPortOe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_hit_cause; busHit |-> $past(busRead); endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("hit without read");
    property p_sel_cause; regFileSelect |-> $past(busRead || busWrite); endproperty
    a_sel_cause: assert property (p_sel_cause) else $error("stray select");
    property p_hit_sel; busHit |-> regFileSelect; endproperty
    a_hit_sel: assert property (p_hit_sel) else $error("hit without select");
    property p_miss_zero; !busHit |-> busRdData == 16'h0000; endproperty
    a_miss_zero: assert property (p_miss_zero) else $error("data on miss");
    property p_idx; busRead |=> regWordIndex == $past(busAddr[7:1]); endproperty
    a_idx: assert property (p_idx) else $error("word index wrong");
    property p_in_only; (secondPortOe & 8'h34) == 8'h00; endproperty
    a_in_only: assert property (p_in_only) else $error("input bit driven");
    property p_od; (secondPortOe & secondPortOut & 8'hc0) == 8'h00; endproperty
    a_od: assert property (p_od) else $error("open drain driven high");
    property p_out_only; $past(rst_b) |-> (secondPortOe & 8'h0a) == 8'h0a; endproperty
    a_out_only: assert property (p_out_only) else $error("output bit released");
    property p_first_out; $past(rst_b) |-> firstPortOe == 8'hff; endproperty
    a_first_out: assert property (p_first_out) else $error("first port not driven");
endmodule // dio_port_block_properties
bind dio_port_block dio_port_block_properties #(.ADDR_WIDTH(ADDR_WIDTH)) props (.sys_clk,
    .rst_b, .busAddr, .busWrite, .busRead, .busRdData, .busHit, .regWordIndex,
    .regFileSelect, .firstPortOe, .secondPortOut, .secondPortOe);

// ---- verif/dio_port_block_test.sv ----
// self-checking testbench for the dual port block
`timescale 1ns/1ns
module dio_port_block_test;
    logic sys_clk = 0, rst_b = 0, busIoSpace = 1, busWrite = 0, busRead = 0;
    logic [19:0] busAddr = 20'h00000;
    logic [15:0] busWrData = 16'h0000;
    logic [7:0] altFirstOut = 8'hff, extVal = 8'h00, extOe = 8'h00;
    logic [7:0] altSecondOut = 8'h00, altSecondOe = 8'h00;
    wire [7:0] altSecondIn;
    wire [15:0] busRdData;
    wire busHit;
    wire [7:0] firstPortOut, firstPortOe, firstPortIn, secondPortOut, secondPortOe, secondPortIn;
    int mismatches = 0, samplesChecked = 0, cyc = 0;
    dio_port_block DUT (.sys_clk, .rst_b, .busAddr, .busIoSpace, .busWrite, .busRead,
        .busWrData, .busRdData, .busHit, .regWordIndex(), .regFileSelect(), .altFirstOut,
        .altSecondOut, .altSecondOe, .altSecondIn, .firstPortIn,
        .firstPortOut, .firstPortOe, .secondPortIn, .secondPortOut, .secondPortOe);
    dio_board_model board (.firstPortOut, .firstPortOe, .secondPortOut, .secondPortOe,
        .extVal, .extOe, .firstPortIn, .secondPortIn);
    initial forever #50 sys_clk = ~sys_clk;
    task automatic wrapUp;
        $display("checks %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            mismatches++;
            wrapUp;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        busAddr = a;
        busWrData = d;
        busWrite = 1;
        @(negedge sys_clk);
        busWrite = 0;
    endtask
    task automatic rd(input logic [19:0] a, input logic [15:0] exp, input logic hit);
        @(negedge sys_clk);
        busAddr = a;
        busRead = 1;
        @(negedge sys_clk);
        busRead = 0;
        chk(busRdData, exp);
        chk({15'h0000, busHit}, {15'h0000, hit});
    endtask
    task automatic t_reset;
        rd(20'h0ff50, 16'h0000, 1'b1);
        rd(20'h0ff54, 16'h0000, 1'b1);
        rd(20'h0ff56, 16'h00ff, 1'b1);
        rd(20'h0ff58, 16'h00ff, 1'b1);
        rd(20'h0ff5c, 16'h0000, 1'b1);
        chk({8'h00, secondPortOe}, 16'h000a);
    endtask
    task automatic t_first;
        wr(20'h0ff56, 16'h00a5);
        @(negedge sys_clk);
        chk({8'h00, firstPortOut}, 16'h00a5);
        altFirstOut = 8'h00;
        wr(20'h0ff54, 16'h0081);
        repeat (6) @(negedge sys_clk);
        chk({8'h00, firstPortOut}, 16'h0024);
        rd(20'h0ff52, 16'h0024, 1'b1);
    endtask
    task automatic t_second;
        wr(20'h0ff5e, 16'h0000);
        @(negedge sys_clk);
        chk({8'h00, secondPortOe}, 16'h00ca);
        chk({8'h00, secondPortOut & secondPortOe}, 16'h0000);
        wr(20'h0ff58, 16'h00fe);
        wr(20'h0ff5e, 16'h00ff);
        @(negedge sys_clk);
        chk({8'h00, secondPortOe}, 16'h000b);
        extOe = 8'hb4;
        extVal = 8'h14;
        repeat (6) @(negedge sys_clk);
        rd(20'h0ff5a, 16'h0055, 1'b1);
    endtask
    task automatic t_alt;
        altSecondOut = 8'h00;
        altSecondOe = 8'hff;
        wr(20'h0ff5c, 16'h00ff);
        @(negedge sys_clk);
        chk({8'h00, secondPortOe}, 16'h000b);
        chk({8'h00, secondPortOut}, 16'h0000);
        repeat (8) @(negedge sys_clk);
        chk({8'h00, altSecondIn}, 16'h0054);
        wr(20'h0ff5c, 16'h0000);
    endtask
    task automatic t_window;
        busIoSpace = 0;
        rd(20'h0ff56, 16'h0000, 1'b0);
        busIoSpace = 1;
        rd(20'h0ff00, 16'h0000, 1'b1);
        wr(20'h0ff52, 16'h0000);
        rd(20'h0ff52, 16'h0024, 1'b1);
        wr(20'h0ff10, 16'h1234);
        rd(20'h0ff10, 16'h1234, 1'b1);
        wr(20'h0fffe, 16'h0010);
        busIoSpace = 0;
        rd(20'h01056, 16'h00a5, 1'b1);
        busIoSpace = 1;
        rd(20'h0ff56, 16'h0000, 1'b0);
    endtask
    initial begin
        repeat (10) @(negedge sys_clk);
        rst_b = 1;
        t_reset;
        t_first;
        t_second;
        t_alt;
        t_window;
        wrapUp;
    end
endmodule // dio_port_block_test
